// ===== logic/sap_rx_pkg.sv
// Purpose: shared constants and types for the serial audio receive port
// Assumes: 25 MHz system clock, bit clock sampled as an ordinary input
// Notes: register offsets are byte addresses on the AXI4-Lite bus
package sap_rx_pkg;
  localparam logic [7:0] OFF_FMT = 8'h33;
  localparam logic [7:0] OFF_WLEN = 8'h34;
  localparam logic [7:0] OFF_CLK_STATUS = 8'h71;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h80;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h84;
  localparam logic [7:0] OFF_LEFT = 8'h88;
  localparam logic [7:0] OFF_RIGHT = 8'h8c;
  localparam logic [7:0] OFF_RATE = 8'h90;
  localparam int FMT_SEL_LSB = 4;
  localparam int FS_SHORT_LSB = 2;
  localparam int WLEN_HI_BIT = 7;
  localparam logic [1:0] FMT_I2S = 2'h0;
  localparam logic [1:0] FMT_TDM = 2'h1;
  localparam logic [1:0] FMT_RJ = 2'h2;
  localparam logic [1:0] FMT_LJ = 2'h3;
  localparam logic [7:0] FMT_RESET = 8'h00;
  localparam logic [7:0] WLEN_RESET = 8'h18;
  localparam logic [5:0] WLEN_MAX = 6'h20;
  localparam int CLK_MHZ = 25;
  localparam int HALT_TIME_US = 40;
  localparam int HALT_CYCLES = HALT_TIME_US * CLK_MHZ;
  localparam logic [9:0] RATIO_32 = 10'h020;
  localparam logic [9:0] RATIO_64 = 10'h040;
  localparam logic [9:0] RATIO_128 = 10'h080;
  localparam logic [9:0] RATIO_256 = 10'h100;
  localparam logic [9:0] RATIO_512 = 10'h200;
  localparam int IRQ_CLK_ERR = 0;
  localparam int IRQ_LEFT = 1;
  localparam int IRQ_RIGHT = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_t;

  typedef struct packed {
    logic bit_clk;
    logic word_clk;
    logic serial_data_in;
  } audio_pins_t;
endpackage

// ===== logic/sync2.sv
// Purpose: two-flop synchroniser for a vector of asynchronous levels
// Assumes: inputs are independent levels
// Notes: only the second stage is visible outside
`timescale 1ns/100ps
`default_nettype none
module sync2 #(
  parameter int W = 3
) (
  input wire logic CLOCK,
  input wire logic RST_B,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_state_t;
  sync_state_t state, next_state;

  always_comb begin
    next_state.meta = async_in;
    next_state.stable = state.meta;
    if (!RST_B) begin
      next_state = '0;
    end
  end

  always_ff @(posedge CLOCK) begin
    state <= next_state;
  end

  assign sync_out = state.stable;
endmodule
`default_nettype wire

// ===== logic/sap_rx.sv
// Purpose: serial audio input port receiver with clock error and hi-z control
// Assumes: host drives bit clock, word clock and data; bit clock well below 12.5 MHz
// Notes: software reaches the port over AXI4-Lite; one level interrupt
//
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - A halted clock or an unsupported bit-to-word clock ratio sets the clock error at 0x71.
// - On a clock halt every output channel is forced to high impedance.
// - When clocks return the port resumes its former state with no software reload.
// - Bits 5:4 of register 0x33 pick I2S, left-justified, right-justified or TDM.
// - Samples are MSB-first two's complement of up to 32 bits.
// - Word length comes from bit 7 of 0x33 together with 0x34.
// - Reset leaves the port in I2S with 24-bit words.
// - In I2S, word clock low carries left and high carries right.
// - In right-justified, word clock high carries left and low carries right.
// - In TDM a rising frame sync starts a new frame.
// - Data shifts in on the bit clock; the word clock is channel select or frame sync.
// - The sample rate is measured by the port itself with no software choice.
module sap_rx
  import sap_rx_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST_B,
  input wire sap_rx_pkg::audio_pins_t PINS,
  input wire sap_rx_pkg::axil_req_t AXI_REQ,
  output sap_rx_pkg::axil_rsp_t AXI_RSP,
  output logic [31:0] LEFT_SAMPLE,
  output logic [31:0] RIGHT_SAMPLE,
  output logic SAMPLE_STROBE,
  output logic OUTPUT_HIZ,
  output logic CLOCK_ERROR,
  output logic IRQ
);
  typedef struct packed {
    logic bclk_d;
    logic wclk_d;
    logic [31:0] shift;
    logic [9:0] bit_cnt;
    logic [9:0] ratio_cnt;
    logic [9:0] ratio;
    logic [15:0] halt_cnt;
    logic halted;
    logic ratio_bad;
    logic [7:0] fmt;
    logic [7:0] wlen;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic [31:0] left;
    logic [31:0] right;
    logic strobe;
    logic hiz;
    logic clk_err;
    logic irq;
    axil_rsp_t rsp;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
  } rx_state_t;

  rx_state_t state, next_state;
  audio_pins_t pins_s;

  sync2 #(
    .W(3)
  ) u_sync (
    .CLOCK(CLOCK),
    .RST_B(RST_B),
    .async_in(PINS),
    .sync_out(pins_s)
  );

  logic bclk_rise;
  logic wclk_rise;
  logic wclk_edge;
  logic [1:0] fmt_sel;
  logic [5:0] word_len;
  logic [5:0] slot_bits;
  logic ratio_ok;
  logic left_phase;
  logic [31:0] rd_data;
  logic rd_hit;
  logic [31:0] aligned;
  logic [31:0] shift_in;
  logic [31:0] aligned_in;
  logic [9:0] bit_idx;
  logic [2:0] events;

  always_comb begin
    bclk_rise = pins_s.bit_clk && !state.bclk_d;
    wclk_edge = bclk_rise && (pins_s.word_clk != state.wclk_d);
    wclk_rise = wclk_edge && pins_s.word_clk;
    fmt_sel = state.fmt[FMT_SEL_LSB +: 2];
    // wider selections saturate at the 32-bit ceiling
    if (state.fmt[WLEN_HI_BIT] || state.wlen > 8'(WLEN_MAX)) begin
      word_len = WLEN_MAX;
    end else begin
      word_len = state.wlen[5:0];
    end
    // per-channel slot is half the frame; right-justified aligns to its end
    slot_bits = state.ratio[6:1];
    ratio_ok = (state.ratio == RATIO_32) || (state.ratio == RATIO_64);
    if (fmt_sel == FMT_TDM) begin
      ratio_ok = (state.ratio == RATIO_128) || (state.ratio == RATIO_256)
        || (state.ratio == RATIO_512);
    end
    // word clock level at sampling chooses the channel; in TDM the bit count does
    if (fmt_sel == FMT_I2S) begin
      left_phase = !state.wclk_d;
    end else if (fmt_sel == FMT_TDM) begin
      left_phase = state.bit_cnt < 10'(WLEN_MAX);
    end else begin
      left_phase = state.wclk_d;
    end
    aligned = state.shift;
    if (word_len != WLEN_MAX) begin
      aligned = state.shift << (6'(WLEN_MAX) - word_len);
    end
    // the same word with the bit now arriving included
    shift_in = {state.shift[30:0], pins_s.serial_data_in};
    aligned_in = shift_in;
    if (word_len != WLEN_MAX) begin
      aligned_in = shift_in << (6'(WLEN_MAX) - word_len);
    end
    bit_idx = state.bit_cnt + 10'h001;
    rd_hit = 1'b1;
    unique case (AXI_REQ.araddr)
      OFF_FMT: rd_data = {24'h00_0000, state.fmt};
      OFF_WLEN: rd_data = {24'h00_0000, state.wlen};
      OFF_CLK_STATUS: rd_data = {31'h0000_0000, state.clk_err};
      OFF_IRQ_STATUS: rd_data = {29'h0000_0000, state.irq_status};
      OFF_IRQ_MASK: rd_data = {29'h0000_0000, state.irq_mask};
      OFF_LEFT: rd_data = state.left;
      OFF_RIGHT: rd_data = state.right;
      OFF_RATE: rd_data = {22'h00_0000, state.ratio};
      default: begin
        rd_data = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_comb begin
    next_state = state;
    events = 3'h0;
    next_state.bclk_d = pins_s.bit_clk;
    next_state.strobe = 1'b0;
    if (bclk_rise) begin
      next_state.wclk_d = pins_s.word_clk;
      next_state.shift = {state.shift[30:0], pins_s.serial_data_in};
      next_state.bit_cnt = state.bit_cnt + 10'h001;
      next_state.ratio_cnt = state.ratio_cnt + 10'h001;
    end
    // a clock that stops running stops the word clock edges that clear the cycle counter
    if (wclk_edge) begin
      next_state.halt_cnt = 16'h0000;
    end else if (state.halt_cnt != 16'(HALT_CYCLES)) begin
      next_state.halt_cnt = state.halt_cnt + 16'h0001;
    end
    next_state.halted = state.halt_cnt == 16'(HALT_CYCLES);
    // frame length is counted between word clock rising edges
    if (wclk_rise) begin
      next_state.ratio = state.ratio_cnt + 10'h001;
      next_state.ratio_cnt = 10'h000;
    end
    next_state.ratio_bad = !ratio_ok;
    // a word ends on a channel edge, or after word_len bits in TDM/LJ/I2S
    if (bclk_rise && !state.halted) begin
      if (fmt_sel == FMT_TDM) begin
        // counter spans the whole frame so idle slots never match either word end
        if (wclk_rise) begin
          next_state.bit_cnt = 10'h001;
        end else if (state.bit_cnt == 10'(word_len)) begin
          next_state.left = aligned;
          events[IRQ_LEFT] = 1'b1;
        end else if (state.bit_cnt == 10'(word_len) + 10'(WLEN_MAX)) begin
          next_state.right = aligned;
          next_state.strobe = 1'b1;
          events[IRQ_RIGHT] = 1'b1;
        end
      end else begin
        if (wclk_edge) begin
          next_state.bit_cnt = 10'h000;
        end
        if (fmt_sel == FMT_RJ) begin
          if (wclk_edge && slot_bits != 6'h00) begin
            if (left_phase) begin
              next_state.left = aligned;
              events[IRQ_LEFT] = 1'b1;
            end else begin
              next_state.right = aligned;
              next_state.strobe = 1'b1;
              events[IRQ_RIGHT] = 1'b1;
            end
          end
        end else if (bit_idx == 10'(word_len - 6'(fmt_sel == FMT_LJ))) begin
          // i2s lags the edge by one bit, so a 32-bit word closes on the next edge
          if (left_phase) begin
            next_state.left = aligned_in;
            events[IRQ_LEFT] = 1'b1;
          end else begin
            next_state.right = aligned_in;
            next_state.strobe = 1'b1;
            events[IRQ_RIGHT] = 1'b1;
          end
        end
      end
    end
    next_state.clk_err = state.halted || state.ratio_bad;
    next_state.hiz = state.halted;
    events[IRQ_CLK_ERR] = next_state.clk_err && !state.clk_err;

    // bus slave: address and data may arrive in either order
    if (AXI_REQ.awvalid && state.rsp.awready) begin
      next_state.aw_held = 1'b1;
      next_state.aw_addr = AXI_REQ.awaddr;
      next_state.rsp.awready = 1'b0;
    end
    if (AXI_REQ.wvalid && state.rsp.wready) begin
      next_state.w_held = 1'b1;
      next_state.w_data = AXI_REQ.wdata;
      next_state.w_strb = AXI_REQ.wstrb;
      next_state.rsp.wready = 1'b0;
    end
    if (state.aw_held && state.w_held && !state.rsp.bvalid) begin
      next_state.rsp.bvalid = 1'b1;
      next_state.rsp.bresp = RESP_OKAY;
      unique case (state.aw_addr)
        OFF_FMT: begin
          if (state.w_strb[0]) begin
            next_state.fmt = state.w_data[7:0];
          end
        end
        OFF_WLEN: begin
          if (state.w_strb[0]) begin
            next_state.wlen = state.w_data[7:0];
          end
        end
        OFF_IRQ_MASK: begin
          if (state.w_strb[0]) begin
            next_state.irq_mask = state.w_data[2:0];
          end
        end
        OFF_CLK_STATUS, OFF_IRQ_STATUS, OFF_LEFT, OFF_RIGHT, OFF_RATE: begin
          next_state.rsp.bresp = RESP_OKAY;
        end
        default: next_state.rsp.bresp = RESP_SLVERR;
      endcase
    end
    if (state.rsp.bvalid && AXI_REQ.bready) begin
      next_state.rsp.bvalid = 1'b0;
      next_state.aw_held = 1'b0;
      next_state.w_held = 1'b0;
      next_state.rsp.awready = 1'b1;
      next_state.rsp.wready = 1'b1;
    end
    if (AXI_REQ.arvalid && state.rsp.arready) begin
      next_state.rsp.arready = 1'b0;
      next_state.rsp.rvalid = 1'b1;
      next_state.rsp.rdata = rd_data;
      next_state.rsp.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
      // status clears on read; a same-cycle event still lands
      if (AXI_REQ.araddr == OFF_IRQ_STATUS) begin
        next_state.irq_status = 3'h0;
      end
    end
    if (state.rsp.rvalid && AXI_REQ.rready) begin
      next_state.rsp.rvalid = 1'b0;
      next_state.rsp.arready = 1'b1;
    end
    next_state.irq_status = next_state.irq_status | events;
    next_state.irq = |(state.irq_status & state.irq_mask);

    if (!RST_B) begin
      next_state = '0;
      next_state.fmt = FMT_RESET;
      next_state.wlen = WLEN_RESET;
      next_state.rsp.awready = 1'b1;
      next_state.rsp.wready = 1'b1;
      next_state.rsp.arready = 1'b1;
    end
  end

  always_ff @(posedge CLOCK) begin
    state <= next_state;
  end

  assign AXI_RSP = state.rsp;
  assign LEFT_SAMPLE = state.left;
  assign RIGHT_SAMPLE = state.right;
  assign SAMPLE_STROBE = state.strobe;
  assign OUTPUT_HIZ = state.hiz;
  assign CLOCK_ERROR = state.clk_err;
  assign IRQ = state.irq;
endmodule
`default_nettype wire

// ===== verification/sap_rx_monitor.sv
// Purpose: concurrent checks on the serial audio receive port pins
// Assumes: halt timer of 1000 cycles, registered outputs
// Notes: quiet counts cycles since the raw word clock last moved
`timescale 1ns/100ps
`default_nettype none
module sap_rx_monitor
  import sap_rx_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST_B,
  input wire sap_rx_pkg::audio_pins_t PINS,
  input wire sap_rx_pkg::axil_req_t AXI_REQ,
  input wire sap_rx_pkg::axil_rsp_t AXI_RSP,
  input wire logic [31:0] LEFT_SAMPLE,
  input wire logic [31:0] RIGHT_SAMPLE,
  input wire logic SAMPLE_STROBE,
  input wire logic OUTPUT_HIZ,
  input wire logic CLOCK_ERROR,
  input wire logic IRQ
);
  logic [10:0] quiet;
  logic last_wc;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_B);
  // raw pin leads the synchroniser, so bounds carry a few cycles of slack
  always_ff @(posedge CLOCK) begin
    last_wc <= PINS.word_clk;
    if (!RST_B || PINS.word_clk != last_wc) quiet <= '0;
    else if (quiet != 11'h7ff) quiet <= quiet + 11'h001;
  end
  sequence s_wr_taken;
    AXI_REQ.awvalid && AXI_RSP.awready && AXI_REQ.wvalid && AXI_RSP.wready;
  endsequence
  sequence s_rd_taken;
    AXI_REQ.arvalid && AXI_RSP.arready;
  endsequence
  property p_halt_flags;
    quiet == 11'h424 |-> OUTPUT_HIZ && CLOCK_ERROR;
  endproperty
  a_halt_flags: assert property (p_halt_flags) else $error("halt not flagged");
  property p_hiz_cause;
    $rose(OUTPUT_HIZ) |-> quiet >= 11'h3de;
  endproperty
  a_hiz_cause: assert property (p_hiz_cause) else $error("hi-z while clocks run");
  property p_hiz_err;
    OUTPUT_HIZ |-> CLOCK_ERROR;
  endproperty
  a_hiz_err: assert property (p_hiz_err) else $error("hi-z without clock error");
  property p_no_capture;
    OUTPUT_HIZ |-> !SAMPLE_STROBE;
  endproperty
  a_no_capture: assert property (p_no_capture) else $error("sample while halted");
  property p_recover;
    $fell(OUTPUT_HIZ) |-> quiet < 11'h010;
  endproperty
  a_recover: assert property (p_recover) else $error("hi-z left without edge");
  property p_right_strobe;
    $changed(RIGHT_SAMPLE) |-> SAMPLE_STROBE;
  endproperty
  a_right_strobe: assert property (p_right_strobe) else $error("right word w/o strobe");
  property p_wr_answer;
    s_wr_taken |-> ##[1:3] AXI_RSP.bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write response late");
  property p_rd_answer;
    s_rd_taken |=> AXI_RSP.rvalid && !AXI_RSP.arready;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read response late");
endmodule
bind sap_rx sap_rx_monitor mon (.CLOCK(CLOCK), .RST_B(RST_B), .PINS(PINS),
  .AXI_REQ(AXI_REQ), .AXI_RSP(AXI_RSP), .LEFT_SAMPLE(LEFT_SAMPLE),
  .RIGHT_SAMPLE(RIGHT_SAMPLE), .SAMPLE_STROBE(SAMPLE_STROBE),
  .OUTPUT_HIZ(OUTPUT_HIZ), .CLOCK_ERROR(CLOCK_ERROR), .IRQ(IRQ));
`default_nettype wire

// ===== verification/sap_host.sv
// Purpose: host model driving bit clock, word clock and serial data
// Assumes: 64 bit clocks a frame, 128 in the frame-sync format
// Notes: clocks stand still while run is low; the data line wanders then
`timescale 1ns/100ps
`default_nettype none
module sap_host
  import sap_rx_pkg::*;
(
  input wire logic run,
  input wire logic [1:0] fmt,
  input wire logic [31:0] left,
  input wire logic [31:0] right,
  output var sap_rx_pkg::audio_pins_t pins
);
  int i;
  int j;
  int len;
  int half;
  initial begin
    pins = '0;
    i = 0;
    forever begin
      half = 160;
      len = (fmt == FMT_TDM) ? 128 : 64;
      if (!run) begin
        pins.bit_clk = 1'b0;
        pins.serial_data_in = ~pins.serial_data_in;
        i = 0;
        #half;
      end else begin
        // i2s lags the channel edge by one bit; tdm slots start on the frame edge
        j = (fmt == FMT_I2S) ? (i + len - 1) % len : i;
        pins.bit_clk = 1'b0;
        pins.word_clk = (fmt == FMT_I2S) ? i >= 32 : (fmt == FMT_TDM) ? i < 64 : i < 32;
        pins.serial_data_in = j < 32 ? left[31 - j] : j < 64 ? right[63 - j] : i[0];
        #half;
        pins.bit_clk = 1'b1;
        #half;
        i = (i + 1) % len;
      end
    end
  end
endmodule
`default_nettype wire

// ===== verification/sap_rx_bench.sv
// Purpose: self-checking bench for the serial audio receive port
// Assumes: host model on the pins, bus master tasks on AXI4-Lite
// Notes: every format is entered after a halt longer than 100 us
`timescale 1ns/100ps
`default_nettype none
module sap_rx_bench;
  import sap_rx_pkg::*;
  logic clock;
  logic rst_b;
  axil_req_t req;
  axil_rsp_t rsp;
  audio_pins_t pins;
  logic [31:0] left_sample;
  logic [31:0] right_sample;
  logic sample_strobe;
  logic output_hiz;
  logic clock_error;
  logic irq;
  logic run;
  logic [1:0] fmt;
  logic [1:0] f;
  logic [31:0] left;
  logic [31:0] right;
  logic [31:0] seed;
  logic [31:0] rd;
  logic [1:0] resp;
  int wl;
  int miscompares;
  int checked;
  sap_rx dut (.CLOCK(clock), .RST_B(rst_b), .PINS(pins), .AXI_REQ(req), .AXI_RSP(rsp),
    .LEFT_SAMPLE(left_sample), .RIGHT_SAMPLE(right_sample), .SAMPLE_STROBE(sample_strobe),
    .OUTPUT_HIZ(output_hiz), .CLOCK_ERROR(clock_error), .IRQ(irq));
  sap_host host (.run(run), .fmt(fmt), .left(left), .right(right), .pins(pins));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  function automatic logic [31:0] step(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // msb-aligned word; right-justified keeps the tail of the slot
  function automatic logic [31:0] exp_word(input logic [1:0] g, input int n, input logic [31:0] w);
    return (g == FMT_RJ) ? w << (32 - n) : w & ~(32'hffff_ffff >> n);
  endfunction
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'h1;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (!rsp.bvalid && n < 50);
    chk_bit(rsp.bvalid, 1'b1);
    req.bready <= 1'b0;
    @(posedge clock);
  endtask
  task automatic axi_read(input logic [7:0] a);
    int n;
    n = 0;
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (!rsp.rvalid && n < 50);
    chk_bit(rsp.rvalid, 1'b1);
    rd = rsp.rdata;
    resp = rsp.rresp;
    req.rready <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wait_strobes(input int k);
    int n;
    n = 0;
    while (k > 0 && n < 20000) begin
      @(posedge clock);
      n++;
      if (sample_strobe) k--;
    end
    chk_bit(k == 0, 1'b1);
  endtask
  task automatic end_of_test;
    $display("checked %0d, miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #(40 * 100000);
    miscompares++;
    end_of_test();
  end
  initial begin
    rst_b = 1'b0;
    req = '0;
    run = 1'b0;
    fmt = FMT_I2S;
    left = '0;
    right = '0;
    seed = 32'hd749_780f;
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    axi_read(OFF_FMT);
    chk_word(rd, {24'h0, FMT_RESET});
    axi_read(OFF_WLEN);
    chk_word(rd, {24'h0, WLEN_RESET});
    axi_read(8'h40);
    chk_word({30'h0, resp}, {30'h0, RESP_SLVERR});
    // last pass resumes with no format or word length reload
    for (int c = 0; c < 9; c++) begin
      f = (c == 8) ? FMT_LJ : c[2:1];
      wl = (c[0] || c == 8) ? 32 : 24;
      run <= 1'b0;
      seed = step(seed);
      left <= seed;
      seed = step(seed);
      right <= seed;
      if (c < 8) begin
        axi_write(OFF_FMT, {24'h0, wl == 32 && f[0], 1'b0, f, 4'h0});
        axi_write(OFF_WLEN, (wl == 32 && !f[0]) ? 32'h0000_0020 : 32'h0000_0018);
      end
      axi_write(OFF_IRQ_MASK, {31'h0, c[0] | c[3]});
      repeat (2600) @(posedge clock);
      fmt <= f;
      chk_bit(output_hiz, 1'b1);
      chk_bit(clock_error, 1'b1);
      chk_bit(irq, c[0] | c[3]);
      axi_read(OFF_CLK_STATUS);
      chk_bit(rd[0], 1'b1);
      axi_read(OFF_IRQ_STATUS);
      chk_bit(rd[IRQ_CLK_ERR], 1'b1);
      chk_bit(rd[IRQ_RIGHT], c != 0);
      repeat (3) @(posedge clock);
      chk_bit(irq, 1'b0);
      run <= 1'b1;
      wait_strobes(4);
      chk_word(left_sample, exp_word(f, wl, left));
      chk_word(right_sample, exp_word(f, wl, right));
      chk_bit(output_hiz, 1'b0);
      chk_bit(clock_error, 1'b0);
      axi_read(OFF_LEFT);
      chk_word(rd, exp_word(f, wl, left));
      axi_read(OFF_RATE);
      chk_word(rd, {22'h0, (f == FMT_TDM) ? RATIO_128 : RATIO_64});
    end
    end_of_test();
  end
endmodule
`default_nettype wire
